/* src/pfgh_override.sv */
// Override logic for Ports F, G and H with an AHB-Lite register slave.
// Assumes pad and port-register inputs synchronous to i_clk and a
// power-on reset that is separate from the chip reset.
`timescale 1ns/1ns
module pfgh_override #(
  parameter bit HAS_PORT_H = 1'b1          // Larger package variant
) (
  input  wire logic        i_clk,          // System clock 100 MHz
  input  wire logic        i_rst_n,        // Chip reset, async
  input  wire logic        i_por_n,        // Power-on reset, async
  input  wire logic        i_hsel,         // AHB select
  input  wire logic [31:0] i_haddr,        // AHB address
  input  wire logic [1:0]  i_htrans,       // AHB transfer type
  input  wire logic        i_hwrite,       // AHB write
  input  wire logic [2:0]  i_hsize,        // AHB size, word only
  input  wire logic [31:0] i_hwdata,       // AHB write data
  input  wire logic        i_hready,       // AHB bus ready
  output logic             o_hreadyout,    // AHB slave ready
  output logic             o_hresp,        // AHB response, OKAY
  output logic      [31:0] o_hrdata,       // AHB read data
  output logic             o_irq,          // Level interrupt
  input  wire logic        i_ir_shift_state, // TAP shifting IR
  input  wire logic        i_dr_shift_state, // TAP shifting DR
  input  wire logic        i_tdo,          // Test data out from TAP
  input  wire logic        i_reset_pin_disable_fuse, // 0 = programmed
  input  wire logic [7:0]  i_pf_pad,       // Port F pad levels
  input  wire logic [7:0]  i_pf_port,      // Port F data register
  input  wire logic [7:0]  i_pf_ddr,       // Port F direction register
  output logic      [7:0]  o_pf_pu,        // Port F pull-up on
  output logic      [7:0]  o_pf_oe,        // Port F drive enable
  output logic      [7:0]  o_pf_do,        // Port F drive value
  output logic      [7:0]  o_pf_ie,        // Port F digital input on
  output logic      [7:0]  o_analog_ch,    // Converter channels 7..0
  input  wire logic [5:0]  i_pg_pad,       // Port G pad levels
  input  wire logic [5:0]  i_pg_port,      // Port G data register
  input  wire logic [5:0]  i_pg_ddr,       // Port G direction register
  output logic      [5:0]  o_pg_pu,        // Port G pull-up on
  output logic      [5:0]  o_pg_oe,        // Port G drive enable
  output logic      [5:0]  o_pg_do,        // Port G drive value
  output logic      [5:0]  o_pg_ie,        // Port G digital input on
  output logic             o_ext_reset_n,  // External reset request
  output logic             o_timer_zero_count_in, // Timer 0 count input
  output logic             o_timer_one_count_in,  // Timer 1 count input
  input  wire logic [7:0]  i_ph_pad,       // Port H pad levels
  input  wire logic [7:0]  i_ph_port,      // Port H data register
  input  wire logic [7:0]  i_ph_ddr,       // Port H direction register
  output logic      [7:0]  o_ph_pu,        // Port H pull-up on
  output logic      [7:0]  o_ph_oe,        // Port H drive enable
  output logic      [7:0]  o_ph_do,        // Port H drive value
  output logic      [7:0]  o_ph_ie,        // Port H digital input on
  output logic      [7:0]  o_pin_change_src_h // Sources 16..23
);
  // -----------------------------------------------------------------
  // Reset release and state
  // -----------------------------------------------------------------
  logic [1:0]           rst_sync_r;
  logic                 rst_n;
  pfgh_pkg::pfgh_state_s st_r;
  pfgh_pkg::pfgh_state_s st_nxt;
  logic                 jtag_port_enable_r;
  logic                 jtag_port_enable_nxt;
  logic                 take;
  logic                 wr_ctrl;
  logic [7:0]           w1c;
  logic [7:0]           h_gate;
  logic [7:0]           h_ev;
  logic [7:0]           ph_pad_en;
  logic [31:0]          rd_word;
  logic [7:0]           pf_ovr;
  logic [7:0]           pf_out_value_override_enable;
  logic                 shifting;

  // Two-stage release so the reset edge is clean inside the block
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  assign o_hreadyout = (st_r.bus != pfgh_pkg::BUS_RWAIT);
  assign o_hresp     = 1'b0;
  assign o_hrdata    = st_r.rdata;
  assign take        = i_hsel & i_htrans[1] & i_hready;
  assign wr_ctrl     = st_r.wr && (st_r.addr == pfgh_pkg::CTRL_OFS);
  assign w1c = (st_r.wr && st_r.addr == pfgh_pkg::STAT_OFS) ? i_hwdata[7:0] : 8'h00;

  // Read mux, sampled one cycle after the address phase
  always_comb begin
    case (st_r.addr)
      pfgh_pkg::CTRL_OFS:   rd_word = {30'h0, st_r.grp, jtag_port_enable_r};
      pfgh_pkg::PCMASK_OFS: rd_word = {24'h0, st_r.pcmask};
      pfgh_pkg::STAT_OFS:   rd_word = {24'h0, st_r.status};
      pfgh_pkg::IMASK_OFS:  rd_word = {24'h0, st_r.imask};
      pfgh_pkg::PADS_OFS:   rd_word = {8'h0, ph_pad_en, 2'h0, i_pg_pad, i_pf_pad};
      default:              rd_word = 32'h0;
    endcase
  end

  // -----------------------------------------------------------------
  // Port H, only on the larger variant
  // -----------------------------------------------------------------
  generate
    if (HAS_PORT_H) begin : g_port_h
      assign ph_pad_en = i_ph_pad;
      assign h_gate    = st_r.pcmask & {8{st_r.grp}};                  // R16
      assign h_ev      = (i_ph_pad ^ st_r.ph_prev) & h_gate;
      assign o_ph_ie   = ~h_gate;                                      // R16
      assign o_ph_pu   = i_ph_port & ~i_ph_ddr;
      assign o_ph_oe   = i_ph_ddr;
      assign o_ph_do   = i_ph_port;
    end else begin : g_no_port_h
      // Smaller package: pins absent, everything held quiet
      assign ph_pad_en = 8'h00;                                        // R14
      assign h_gate    = 8'h00;
      assign h_ev      = 8'h00;
      assign o_ph_ie   = 8'h00;
      assign o_ph_pu   = 8'h00;
      assign o_ph_oe   = 8'h00;
      assign o_ph_do   = 8'h00;
    end
  endgenerate
  assign o_pin_change_src_h = st_r.pcsrc;                              // R15

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.analog  = i_pf_pad;                                         // R1
    st_nxt.t0      = i_pg_pad[pfgh_pkg::PG_T0_BIT];                    // R13
    st_nxt.t1      = i_pg_pad[pfgh_pkg::PG_T1_BIT];                    // R13
    st_nxt.pcsrc   = ph_pad_en;                                        // R15
    st_nxt.ph_prev = ph_pad_en;
    // Event set wins over a same-cycle clear
    st_nxt.status  = (st_r.status & ~w1c) | h_ev;
    st_nxt.wr      = 1'b0;
    if (st_r.wr) begin
      case (st_r.addr)
        pfgh_pkg::CTRL_OFS:   st_nxt.grp    = i_hwdata[pfgh_pkg::CTRL_GRP];
        pfgh_pkg::PCMASK_OFS: st_nxt.pcmask = i_hwdata[7:0];
        pfgh_pkg::IMASK_OFS:  st_nxt.imask  = i_hwdata[7:0];
        default:              st_nxt.grp    = st_r.grp;
      endcase
    end
    case (st_r.bus)
      pfgh_pkg::BUS_RWAIT: begin
        st_nxt.rdata = rd_word;
        st_nxt.bus   = pfgh_pkg::BUS_RDONE;
      end
      default: st_nxt.bus = pfgh_pkg::BUS_IDLE;
    endcase
    if (take) begin
      st_nxt.addr = i_haddr[7:0];
      st_nxt.wr   = i_hwrite;
      if (!i_hwrite) begin
        st_nxt.bus = pfgh_pkg::BUS_RWAIT;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{bus: pfgh_pkg::BUS_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // JTAG enable lives on power-on reset only, so chip reset keeps it
  assign jtag_port_enable_nxt = wr_ctrl ? i_hwdata[pfgh_pkg::CTRL_JTAG] : jtag_port_enable_r;
  always_ff @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      jtag_port_enable_r <= 1'b0;
    end else begin
      jtag_port_enable_r <= jtag_port_enable_nxt;                      // R18
    end
  end

  assign o_irq = |(st_r.status & st_r.imask);

  // -----------------------------------------------------------------
  // Port F overrides
  // -----------------------------------------------------------------
  // Combinational from the held enable so pull-ups persist in reset
  assign shifting = i_ir_shift_state | i_dr_shift_state;
  assign pf_ovr   = jtag_port_enable_r ? pfgh_pkg::PF_JTAG_MASK : 8'h00; // R8
  assign pf_out_value_override_enable  = pf_ovr & pfgh_pkg::PF_TDO_MASK;                    // R9
  assign o_pf_pu  = (pf_ovr & pfgh_pkg::PF_JTAG_MASK) | (~pf_ovr & i_pf_port & ~i_pf_ddr); // R3
  assign o_pf_oe  = (~pf_ovr & i_pf_ddr) | (pf_out_value_override_enable & {8{shifting}});  // R5
  assign o_pf_do  = (~pf_out_value_override_enable & i_pf_port) | (pf_out_value_override_enable & {8{i_tdo}});   // R17
  assign o_pf_ie  = ~pf_ovr | (pf_ovr & pfgh_pkg::PF_TCK_MASK);        // R7 R4
  assign o_analog_ch = st_r.analog;                                    // R10

  // -----------------------------------------------------------------
  // Port G overrides
  // -----------------------------------------------------------------
  assign o_pg_pu = (i_pg_port & ~i_pg_ddr) | pfgh_pkg::PG_RST_MASK;    // R11
  assign o_pg_oe = i_pg_ddr & ~pfgh_pkg::PG_RST_MASK;                  // R11
  assign o_pg_do = i_pg_port;                                          // R13
  assign o_pg_ie = 6'h3f;
  assign o_ext_reset_n = i_reset_pin_disable_fuse ? i_pg_pad[pfgh_pkg::PG_RST_BIT] : 1'b1; // R12
  assign o_timer_zero_count_in = st_r.t0;
  assign o_timer_one_count_in  = st_r.t1;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  // One clock domain; checks sleep while the chip reset is low, so the
  // pad overrides inside the reset window are left to the bench
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  // A pad edge on an enabled Port H pin
  sequence s_pin_event;
    |h_ev;
  endsequence
  // Edge in the status word next cycle and, unless cleared, the one after
  sequence s_event_held;
    (st_r.status & $past(h_ev)) == $past(h_ev) ##1
      ((st_r.status & $past(h_ev, 2)) == $past(h_ev, 2) || $past(|w1c));
  endsequence
  // A read accepted in its address phase
  sequence s_read_addr;
    take && !i_hwrite;
  endsequence
  // One wait state, then the answer
  sequence s_read_answer;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  // No control write, then a cycle outside power-on reset
  sequence s_jtag_quiet;
    !wr_ctrl ##1 i_por_n;
  endsequence

  // Converter channels are a one-cycle copy of the pads
  a_analog_route: assert property (                                    // R1
    rst_n |=> o_analog_ch == $past(i_pf_pad))
    else $error("analog channel not following pad");
  // Pull-ups on the three test inputs while the enable is held
  a_jtag_pullup: assert property (                                     // R3
    jtag_port_enable_r |->
      (o_pf_pu & pfgh_pkg::PF_PULL_MASK) == pfgh_pkg::PF_PULL_MASK)
    else $error("jtag pull-up missing");
  a_tdi_input: assert property (jtag_port_enable_r |-> !o_pf_oe[7] && !o_pf_ie[7]) // R4
    else $error("tdi not held as input");
  // Test data pin drives only while shifting, and drives the tap bit
  a_tdo_drive: assert property (                                       // R5
    jtag_port_enable_r |-> o_pf_oe[6] == shifting && o_pf_do[6] == i_tdo)
    else $error("tdo drive wrong");
  a_tck_gate: assert property (                                        // R8
    jtag_port_enable_r |-> o_pf_ie[4] && !o_pf_oe[4] && !o_pf_ie[5])
    else $error("tck or tms override wrong");
  // Digital input kept on the test clock pin alone
  a_input_gate: assert property (                                      // R9
    jtag_port_enable_r |-> o_pf_ie[7:4] == 4'h1)
    else $error("jtag input gate values wrong");
  // Without the enable the port registers rule every bit
  a_gpio_free: assert property (                                       // R17
    !jtag_port_enable_r |-> o_pf_oe == i_pf_ddr && o_pf_do == i_pf_port && o_pf_ie == 8'hff)
    else $error("port f override without enable");
  a_low_pass: assert property (o_pf_oe[3:0] == i_pf_ddr[3:0] && o_pf_ie[3:0] == 4'hf) // R10
    else $error("port f low bits overridden");
  a_pg5_input: assert property (!o_pg_oe[5] && o_pg_pu[5]) // R11
    else $error("port g bit 5 not input with pull-up");
  a_fuse_gpio: assert property (!i_reset_pin_disable_fuse |-> o_ext_reset_n) // R12
    else $error("reset requested while fuse programmed");
  // With the fuse left alone the pin is the reset request
  a_fuse_reset: assert property (                                      // R12
    i_reset_pin_disable_fuse |-> o_ext_reset_n == i_pg_pad[pfgh_pkg::PG_RST_BIT])
    else $error("reset request not following pin");
  a_timer_feed: assert property (                                      // R13
    rst_n |=> o_timer_zero_count_in == $past(i_pg_pad[4]) &&
      o_timer_one_count_in == $past(i_pg_pad[3]))
    else $error("timer count input wrong");
  // Smaller package: Port H sources and drivers stay low
  a_no_port_h: assert property (                                       // R14
    !HAS_PORT_H |-> o_pin_change_src_h == 8'h00 && o_ph_oe == 8'h00)
    else $error("port h active on small variant");
  // Source 16 plus n is pad n, one cycle late
  a_pc_source: assert property (                                       // R15
    HAS_PORT_H && rst_n |=> o_pin_change_src_h == $past(i_ph_pad))
    else $error("pin change source wrong");
  // Input gate closes on enabled pins only; drivers pass through
  a_ph_gate: assert property (                                         // R16
    HAS_PORT_H |-> o_ph_ie == (st_r.grp ? ~st_r.pcmask : 8'hff) &&
      o_ph_oe == i_ph_ddr && o_ph_do == i_ph_port)
    else $error("port h override wrong");
  a_pc_sticky: assert property (s_pin_event |=> s_event_held) // R16
    else $error("pin change event lost");
  a_read_wait: assert property (s_read_addr |=> s_read_answer)
    else $error("read wait state wrong");
  // Only a control write moves the enable outside power-on reset
  a_jtag_hold: assert property (s_jtag_quiet |-> $stable(jtag_port_enable_r)) // R18
    else $error("jtag enable changed without write");
  a_jtag_write: assert property (                                      // R18
    wr_ctrl && i_por_n |=> jtag_port_enable_r == $past(i_hwdata[pfgh_pkg::CTRL_JTAG]))
    else $error("jtag enable write lost");

endmodule // pfgh_override

/* src/pfgh_pkg.sv */
// Package for the Port F/G/H alternate-function override block.
// Assumes one 100 MHz clock and an AHB-Lite register bus.
// Contract
// [R1] Port F bit n feeds analog channel n, bits 0 to 7.
// [R2] Software must not toggle Port F outputs during a conversion.
// [R3] JTAG enabled: pull-ups on TDI, TMS, TCK stay on, even through reset.
// [R4] JTAG enabled: TDI is scan input only, never general I/O.
// [R5] TDO drives only in shift states; otherwise it is pulled high.
// [R6] Tester steers the TAP with TMS and clocks it with TCK.
// [R7] JTAG runs on the test clock from Port F bit 4.
// [R8] JTAG enable forces pull-up 1, direction input (bit 6 output when shifting).
// [R9] Bit 6 output value is TDO; input gate value 1 on bit 4 only.
// [R10] Port F bits 3 to 0 take no override; pads go to the converter.
// [R11] Port G bit 5 is input only with pull-up always on.
// [R12] Reset-disable fuse programmed: Port G bit 5 is a plain input.
// [R13] Port G bits 4 and 3 feed timer 0 and 1 count inputs, no overrides.
// [R14] Port H logic exists only on the larger variant.
// [R15] Port H bit n is pin-change source 16 plus n.
// [R16] Port H input gate override is mask AND group enable, value 0.
// [R17] An asserted override replaces the port register setting.
// [R18] JTAG enable is a registered level that survives chip reset.
package pfgh_pkg;
  // -----------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] PCMASK_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS   = 8'h08;
  localparam logic [7:0] IMASK_OFS  = 8'h0c;
  localparam logic [7:0] PADS_OFS   = 8'h10;
  localparam int         CTRL_JTAG  = 0;
  localparam int         CTRL_GRP   = 1;
  // -----------------------------------------------------------------
  // Pin masks
  // -----------------------------------------------------------------
  localparam logic [7:0] PF_JTAG_MASK = 8'hf0;
  localparam logic [7:0] PF_TDO_MASK  = 8'h40;
  localparam logic [7:0] PF_TCK_MASK  = 8'h10;
  localparam logic [7:0] PF_PULL_MASK = 8'hb0;
  localparam logic [5:0] PG_RST_MASK  = 6'h20;
  localparam int         PG_RST_BIT   = 5;
  localparam int         PG_T0_BIT    = 4;
  localparam int         PG_T1_BIT    = 3;
  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_RWAIT = 3'b010,
    BUS_RDONE = 3'b100
  } pfgh_bus_e;
  typedef struct packed {
    pfgh_bus_e   bus;
    logic [7:0]  addr;
    logic        wr;
    logic        grp;
    logic [7:0]  pcmask;
    logic [7:0]  status;
    logic [7:0]  imask;
    logic [31:0] rdata;
    logic [7:0]  ph_prev;
    logic [7:0]  analog;
    logic        t0;
    logic        t1;
    logic [7:0]  pcsrc;
  } pfgh_state_s;
endpackage

/* tb/pfgh_tester.sv */
// Tester model: TAP shift states, test data out and the test clock.
// Assumes the bench picks the TAP state; pads change only on i_clk.
`timescale 1ns/1ns
module pfgh_tester (
  input  wire logic       i_clk,       // System clock
  input  wire logic [1:0] i_mode,      // 0 idle, 1 IR shift, 2 DR shift
  input  wire logic       i_bit,       // Bit the TAP shifts out
  output logic            o_ir_shift,  // TAP in IR shift
  output logic            o_dr_shift,  // TAP in DR shift
  output logic            o_tdo,       // Test data out to the block
  output logic      [3:0] o_pads       // Pads 7..4: data in, out, select, clock
);
  logic tck_r = 1'b0;
  // Test clock stands still outside shifts so idle pads stay quiet
  always @(posedge i_clk) tck_r <= (i_mode != 2'd0) ? ~tck_r : 1'b0;
  assign o_ir_shift = (i_mode == 2'd1);
  assign o_dr_shift = (i_mode == 2'd2);
  // Outside shifts the TAP output is stale: show its inverse
  assign o_tdo      = (i_mode != 2'd0) ? i_bit : ~i_bit;
  assign o_pads     = {1'b1, 1'b1, o_ir_shift | o_dr_shift, tck_r};
endmodule // pfgh_tester

/* tb/test_port_fgh_alternate_override.sv */
// Self-checking bench for the override block over AHB-Lite.
// Assumes one 100 MHz clock and the tester model in pfgh_tester.
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_port_fgh_alternate_override;
  logic i_clk, i_rst_n, i_por_n, hsel, hwrite, hready, hresp, irq, fuse, irs, drs, tdo, t0, t1;
  logic extr, tbit;
  logic [1:0] htrans, mode;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0] pfl, pf_port, pf_ddr, pf_pu, pf_oe, pf_do, pf_ie, ach, ph_pad, ph_port, ph_ddr;
  logic [7:0] ph_pu, ph_oe, ph_do, ph_ie, pcs;
  logic [5:0] pg_pad, pg_port, pg_ddr, pg_pu, pg_oe, pg_do, pg_ie;
  logic [3:0] jp;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  pfgh_override pfgh_override_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
    .o_hrdata(hrdata), .o_irq(irq), .i_ir_shift_state(irs), .i_dr_shift_state(drs),
    .i_tdo(tdo), .i_reset_pin_disable_fuse(fuse), .i_pf_pad({jp, pfl[3:0]}),
    .i_pf_port(pf_port), .i_pf_ddr(pf_ddr), .o_pf_pu(pf_pu), .o_pf_oe(pf_oe),
    .o_pf_do(pf_do), .o_pf_ie(pf_ie), .o_analog_ch(ach), .i_pg_pad(pg_pad),
    .i_pg_port(pg_port), .i_pg_ddr(pg_ddr), .o_pg_pu(pg_pu), .o_pg_oe(pg_oe),
    .o_pg_do(pg_do), .o_pg_ie(pg_ie), .o_ext_reset_n(extr), .o_timer_zero_count_in(t0),
    .o_timer_one_count_in(t1), .i_ph_pad(ph_pad), .i_ph_port(ph_port), .i_ph_ddr(ph_ddr),
    .o_ph_pu(ph_pu), .o_ph_oe(ph_oe), .o_ph_do(ph_do), .o_ph_ie(ph_ie),
    .o_pin_change_src_h(pcs));
  pfgh_tester pfgh_tester_i (.i_clk(i_clk), .i_mode(mode), .i_bit(tbit), .o_ir_shift(irs),
    .o_dr_shift(drs), .o_tdo(tdo), .o_pads(jp));
  // ----------------------------------------------------------------
  // Clock, hang guard, verdict
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Whole run is well under 1000 cycles; a hang never waits forever
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Bus master: starts after a rising edge, ready sampled at rising edges
  // ----------------------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    q = hrdata;
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {i_rst_n, i_por_n, hsel, hwrite, hwdata, haddr, htrans, mode, tbit} = '0;
    {pfl, pf_port, pf_ddr, pg_pad, pg_port, pg_ddr} = {8'h03, 8'h5a, 8'h0f, 6'h10, 6'h00, 6'h3f};
    {ph_pad, ph_port, ph_ddr, fuse} = {24'h0, 1'b1};
    cyc_n(20);
    {i_rst_n, i_por_n} <= 2'b11;
    cyc_n(3);
    ahb(1'b0, 8'h14, 32'h0);
    `CHK(q, 32'h0)
    @(negedge i_clk);
    `CHK({pf_pu, pf_oe, pf_do, pf_ie}, 32'h500f5aff)
    `CHK({pg_pu[5], pg_oe, extr, t0, t1, ach}, 18'h2fac3)
    `CHK({hresp, pg_do, pg_ie, pg_pu}, 19'h00fe0)
    ahb(1'b0, 8'h10, 32'h0);
    `CHK(q, 32'h000010c3)
    fuse <= 1'b0;
    @(negedge i_clk);
    `CHK(extr, 1'b1)
    $display("test plain ports done");
    ahb(1'b1, 8'h00, 32'h1);
    for (int m = 0; m < 3; m++) for (int b = 0; b < 2; b++) begin
      mode <= m[1:0];
      tbit <= b[0];
      @(negedge i_clk);
      `CHK({pf_pu, pf_ie}, 16'hf01f)
      `CHK(pf_oe, {1'b0, m != 0, 6'h0f})
      `CHK(pf_do, {1'b0, (m != 0) ? b[0] : ~b[0], 6'h1a})
      @(posedge i_clk);
    end
    mode <= 2'd0;
    i_rst_n <= 1'b0;
    @(negedge i_clk);
    `CHK({pf_pu, pf_oe}, 16'hf00f)
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    cyc_n(3);
    ahb(1'b0, 8'h00, 32'h0);
    `CHK(q[0], 1'b1)
    i_por_n <= 1'b0;
    @(negedge i_clk);
    `CHK(pf_pu, 8'h50)
    @(posedge i_clk);
    i_por_n <= 1'b1;
    $display("test jtag overrides done");
    ahb(1'b1, 8'h04, 32'hff);
    ahb(1'b1, 8'h00, 32'h2);
    ahb(1'b1, 8'h0c, 32'h80);
    @(negedge i_clk);
    `CHK({ph_ie, ph_pu, ph_oe, ph_do}, 32'h0)
    @(posedge i_clk);
    ph_pad <= 8'h80;
    cyc_n(3);
    ahb(1'b0, 8'h08, 32'h0);
    `CHK({q, irq, pcs}, {32'h80, 1'b1, 8'h80})
    ahb(1'b1, 8'h08, 32'h80);
    ph_pad <= 8'h81;
    cyc_n(3);
    ahb(1'b0, 8'h08, 32'h0);
    `CHK({q, irq}, {32'h01, 1'b0})
    $display("test port h done");
    wrap_up();
  end
endmodule // test_port_fgh_alternate_override
